// >>> src/dvfh_regs.sv
// Notes on behaviour
// - write to last-send port queues quadlet marked last and commits the packet
// - write to first-continue port queues a non-final quadlet, no commit
// - each receive port read returns next fifo quadlet and pops it
// - empty receive fifo: read returns last delivered quadlet, fifo untouched
// - receive port and captured headers read zero after any reset
// - isochronous header captured whole into a read-only register
// - common header 0 captured with its two top bits forced zero
// - common header 1 top bits forced one-zero, video bits 14-15 zero
// - trailer keeps speed bits 14-15 and error status 28-31 only
// - in video mode cell header bytes 0-7 captured into two registers
// - transmit cell header bytes offered for insertion when enable set
// - increment bit set: each non-busy ack advances destination address
// - auto header bits 1-13 read zero, rest writable, reset 0001_0010
`timescale 1ns/1ns
`default_nettype none
`include "dvfh_defines.svh"

module dvfh_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic in_ready_ff;
  logic out_valid_ff;
  logic do_push;
  logic do_pop;

  assign do_push = in_valid & in_ready_ff;
  assign do_pop = out_valid_ff & out_ready;
  assign nxt_count = count_ff + CW'(do_push) - CW'(do_pop);
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem[rd_ptr_ff];

  // storage has no reset; only the pointers decide what is valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap at depth so non power-of-two depths also work
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (clr) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // full and empty kept as flops so handshakes leave straight from them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else if (clr) begin
      count_ff <= '0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      in_ready_ff <= nxt_count != CW'(DEPTH);
      out_valid_ff <= nxt_count != '0;
    end
  end
endmodule : dvfh_fifo

module dvfh_regs #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dvfh_pkg::dvfh_tx_word_t tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [31:0] rx_quad,
  output logic rx_ready,
  input wire dvfh_pkg::dvfh_rx_capture_t rx_capture,
  input wire logic ack_not_busy,
  output dvfh_pkg::dvfh_cell_insert_t cell_insert,
  output logic addr_advance
);
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, pop_ok_ff;
  logic hit, acc, done, stall;
  logic [31:0] last_rx_ff, iso_ff, cip0_ff, cip1_ff, trailer_ff;
  logic [31:0] rx_cell_lo_ff, rx_cell_hi_ff, tx_cell_lo_ff, tx_cell_hi_ff;
  logic [31:0] auto_hdr0_ff, ctrl_ff;
  logic [3:0] pkt_cnt_ff;
  dvfh_pkg::dvfh_tx_word_t tx_in, tx_head, tx_word_ff;
  logic tx_valid_ff, tx_in_ready, tx_head_valid, tx_take, tx_push;
  logic rx_head_valid, rx_pop;
  logic [31:0] rx_head;
  logic addr_advance_ff;
  dvfh_pkg::dvfh_cell_insert_t cell_insert_ff;
  logic wr_first, wr_last, rd_rx;

  // apb phases: acc is the first access cycle, done the completing one
  assign acc = psel & penable & ~pready_ff;
  assign done = psel & penable & pready_ff;
  assign wr_first = pwrite & (paddr == `DVFH_OFF_TX_FIRST);
  assign wr_last = pwrite & (paddr == `DVFH_OFF_TX_LAST);
  assign rd_rx = ~pwrite & (paddr == `DVFH_OFF_RX_DATA);
  // a full transmit fifo holds pready low: back-pressure to software
  assign stall = (wr_first | wr_last) & ~tx_in_ready;

  // read mux and decode; write-only ports read as zero
  always_comb begin
    hit = 1'b1;
    nxt_prdata = '0;
    case (paddr)
      `DVFH_OFF_TX_FIRST, `DVFH_OFF_TX_LAST: nxt_prdata = '0;
      `DVFH_OFF_RX_DATA: nxt_prdata = rx_head_valid ? rx_head : last_rx_ff;
      `DVFH_OFF_RX_ISO: nxt_prdata = iso_ff;
      `DVFH_OFF_RX_CIP0: nxt_prdata = cip0_ff;
      `DVFH_OFF_RX_CIP1: nxt_prdata = cip1_ff;
      `DVFH_OFF_RX_TRAILER: nxt_prdata = trailer_ff;
      `DVFH_OFF_RX_CELL_LO: nxt_prdata = rx_cell_lo_ff;
      `DVFH_OFF_RX_CELL_HI: nxt_prdata = rx_cell_hi_ff;
      `DVFH_OFF_TX_CELL_LO: nxt_prdata = tx_cell_lo_ff;
      `DVFH_OFF_TX_CELL_HI: nxt_prdata = tx_cell_hi_ff;
      `DVFH_OFF_AUTO_HDR0: nxt_prdata = auto_hdr0_ff;
      `DVFH_OFF_CTRL: nxt_prdata = ctrl_ff;
      default: hit = 1'b0;
    endcase
  end

  // handshake: one wait state, data and error prepared before pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      pop_ok_ff <= 1'b0;
    end else if (done) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      pop_ok_ff <= 1'b0;
    end else if (acc && !stall) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~hit;
      prdata_ff <= pwrite ? '0 : nxt_prdata;
      // only this port pops, so the head stays put until done
      pop_ok_ff <= rd_rx & rx_head_valid;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // transmit path: software writes feed the fifo at completion
  assign tx_push = done & (wr_first | wr_last);
  assign tx_in.last = wr_last;
  assign tx_in.quad = pwdata;

  dvfh_fifo #(
    .W($bits(dvfh_pkg::dvfh_tx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .clr(soft_reset),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(tx_in),
    .out_valid(tx_head_valid),
    .out_ready(tx_take),
    .out_data(tx_head)
  );

  // nothing leaves until a whole packet is committed
  assign tx_take = tx_head_valid & (pkt_cnt_ff != '0) &
                   (~tx_valid_ff | tx_ready);

  // committed packet count: last-send adds one, departing last subtracts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_cnt_ff <= '0;
    end else if (soft_reset) begin
      pkt_cnt_ff <= '0;
    end else begin
      pkt_cnt_ff <= pkt_cnt_ff + 4'(done & wr_last)
                    - 4'(tx_take & tx_head.last);
    end
  end

  // output stage toward the packet engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_ff <= 1'b0;
      tx_word_ff <= '0;
    end else if (soft_reset) begin
      tx_valid_ff <= 1'b0;
      tx_word_ff <= '0;
    end else if (tx_take) begin
      tx_valid_ff <= 1'b1;
      tx_word_ff <= tx_head;
    end else if (tx_ready) begin
      tx_valid_ff <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_word = tx_word_ff;

  // receive path
  assign rx_pop = done & pop_ok_ff;

  dvfh_fifo #(
    .W(32),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .clr(soft_reset),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_quad),
    .out_valid(rx_head_valid),
    .out_ready(rx_pop),
    .out_data(rx_head)
  );

  // last delivered quadlet, replayed when the fifo runs dry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rx_ff <= '0;
    end else if (soft_reset) begin
      last_rx_ff <= '0;
    end else if (rx_pop) begin
      last_rx_ff <= rx_head;
    end
  end

  // captured headers; writes from software never touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iso_ff <= '0;
      cip0_ff <= '0;
      cip1_ff <= '0;
      trailer_ff <= '0;
      rx_cell_lo_ff <= '0;
      rx_cell_hi_ff <= '0;
    end else if (soft_reset) begin
      iso_ff <= '0;
      cip0_ff <= '0;
      cip1_ff <= '0;
      trailer_ff <= '0;
      rx_cell_lo_ff <= '0;
      rx_cell_hi_ff <= '0;
    end else if (rx_capture.valid) begin
      unique case (rx_capture.kind)
        dvfh_pkg::CAP_ISO: iso_ff <= rx_capture.word;
        dvfh_pkg::CAP_CIP0:
          cip0_ff <= {`DVFH_CIP0_MARK, rx_capture.word[29:0]};
        dvfh_pkg::CAP_CIP1: begin
          // video format keeps bits 14-15 at zero whatever arrives
          cip1_ff <= {`DVFH_CIP1_MARK, rx_capture.word[29:0]} &
                     (ctrl_ff[`DVFH_CTRL_VIDEO_BIT] ?
                      `DVFH_CIP1_VIDEO_ZERO_MASK : 32'hffff_ffff);
        end
        dvfh_pkg::CAP_TRAILER:
          trailer_ff <= rx_capture.word & `DVFH_TRL_SPEED_MASK;
        dvfh_pkg::CAP_CELL_LO: begin
          if (ctrl_ff[`DVFH_CTRL_VIDEO_BIT]) begin
            rx_cell_lo_ff <= rx_capture.word;
          end
        end
        dvfh_pkg::CAP_CELL_HI: begin
          if (ctrl_ff[`DVFH_CTRL_VIDEO_BIT]) begin
            rx_cell_hi_ff <= rx_capture.word;
          end
        end
        default: ;
      endcase
    end
  end

  // software-written registers take effect at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cell_lo_ff <= '0;
      tx_cell_hi_ff <= '0;
      auto_hdr0_ff <= `DVFH_AUTO_HDR0_RST;
      ctrl_ff <= '0;
    end else if (soft_reset) begin
      tx_cell_lo_ff <= '0;
      tx_cell_hi_ff <= '0;
      auto_hdr0_ff <= `DVFH_AUTO_HDR0_RST;
      ctrl_ff <= '0;
    end else if (done && pwrite) begin
      if (paddr == `DVFH_OFF_TX_CELL_LO) tx_cell_lo_ff <= pwdata;
      if (paddr == `DVFH_OFF_TX_CELL_HI) tx_cell_hi_ff <= pwdata;
      if (paddr == `DVFH_OFF_AUTO_HDR0) begin
        auto_hdr0_ff <= pwdata & `DVFH_AUTO_HDR0_WMASK;
      end
      if (paddr == `DVFH_OFF_CTRL) ctrl_ff <= pwdata & 32'h0000_0003;
    end
  end

  // insertion bytes and the address advance strobe for the engines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_insert_ff <= '0;
      addr_advance_ff <= 1'b0;
    end else begin
      cell_insert_ff.enable <= ctrl_ff[`DVFH_CTRL_INSERT_BIT];
      cell_insert_ff.bytes <= {tx_cell_lo_ff, tx_cell_hi_ff};
      addr_advance_ff <= ack_not_busy &
                         auto_hdr0_ff[`DVFH_AUTO_HDR0_INC_BIT];
    end
  end

  assign cell_insert = cell_insert_ff;
  assign addr_advance = addr_advance_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rx_prep;
    acc && !stall && rd_rx && rx_head_valid;
  endsequence

  sequence s_empty_prep;
    acc && !stall && rd_rx && !rx_head_valid;
  endsequence

  chk_last_commit: assert property (
    done && wr_last && !(tx_take && tx_head.last) && !soft_reset
    |=> pkt_cnt_ff == $past(pkt_cnt_ff) + 4'h1)
    else $error("last-send write did not commit a packet");
  chk_first_nocommit: assert property (
    done && wr_first && !(tx_take && tx_head.last) && !soft_reset
    |=> $stable(pkt_cnt_ff))
    else $error("first-continue write changed commit count");
  chk_rx_pop_next: assert property (
    s_rx_prep |=> (done && rx_pop) ##1 (last_rx_ff == $past(rx_head, 2)))
    else $error("receive read did not pop the head quadlet");
  chk_rx_empty_hold: assert property (
    s_empty_prep |=> prdata_ff == $past(last_rx_ff) && !rx_pop)
    else $error("empty receive read did not replay last quadlet");
  chk_reset_zero: assert property (
    soft_reset |=> last_rx_ff == '0 && iso_ff == '0 && trailer_ff == '0)
    else $error("captured registers not cleared by soft reset");
  chk_iso_capture: assert property (
    rx_capture.valid && rx_capture.kind == dvfh_pkg::CAP_ISO && !soft_reset
    |=> iso_ff == $past(rx_capture.word))
    else $error("isochronous header not captured");
  chk_cip_marks: assert property (
    cip0_ff[31:30] == 2'h0 && (cip1_ff == '0 || cip1_ff[31:30] == 2'h2))
    else $error("common header mark bits wrong");
  chk_cell_capture: assert property (
    rx_capture.valid && rx_capture.kind == dvfh_pkg::CAP_CELL_LO &&
    ctrl_ff[`DVFH_CTRL_VIDEO_BIT] && !soft_reset
    |=> rx_cell_lo_ff == $past(rx_capture.word))
    else $error("cell header bytes not captured in video mode");
  chk_addr_advance: assert property (
    ack_not_busy && auto_hdr0_ff[`DVFH_AUTO_HDR0_INC_BIT]
    |=> addr_advance_ff ##1
        (addr_advance_ff == ($past(ack_not_busy) &&
                             $past(auto_hdr0_ff[`DVFH_AUTO_HDR0_INC_BIT]))))
    else $error("address advance missing after non-busy ack");
  chk_hdr_reserved: assert property (
    auto_hdr0_ff[30:18] == 13'h0)
    else $error("reserved auto header bits not zero");
endmodule : dvfh_regs

`default_nettype wire

// >>> src/dvfh_defines.svh
`ifndef DVFH_DEFINES_SVH
`define DVFH_DEFINES_SVH

// register byte offsets on the apb window
`define DVFH_OFF_TX_FIRST 12'h160
`define DVFH_OFF_TX_LAST 12'h164
`define DVFH_OFF_RX_DATA 12'h168
`define DVFH_OFF_RX_ISO 12'h178
`define DVFH_OFF_RX_CIP0 12'h17c
`define DVFH_OFF_RX_CIP1 12'h180
`define DVFH_OFF_RX_TRAILER 12'h184
`define DVFH_OFF_RX_CELL_LO 12'h198
`define DVFH_OFF_RX_CELL_HI 12'h19c
`define DVFH_OFF_TX_CELL_LO 12'h1a4
`define DVFH_OFF_TX_CELL_HI 12'h1a8
`define DVFH_OFF_AUTO_HDR0 12'h1b0
`define DVFH_OFF_CTRL 12'h1f0

// reset values and write masks
`define DVFH_AUTO_HDR0_RST 32'h0001_0010
`define DVFH_AUTO_HDR0_WMASK 32'h8003_ffff
`define DVFH_ZERO_RST 32'h0000_0000

// field positions (msb-first numbering maps to sv bit 31 - n)
`define DVFH_AUTO_HDR0_INC_BIT 31
`define DVFH_CTRL_INSERT_BIT 0
`define DVFH_CTRL_VIDEO_BIT 1
`define DVFH_TRL_SPEED_MASK 32'h0003_000f
`define DVFH_CIP0_MARK 2'h0
`define DVFH_CIP1_MARK 2'h2
`define DVFH_CIP1_VIDEO_ZERO_MASK 32'hfffc_ffff

`endif

// >>> src/dvfh_pkg.sv
`default_nettype none
package dvfh_pkg;

  // which captured header the receive control logic is offering
  typedef enum logic [2:0] {
    CAP_ISO,
    CAP_CIP0,
    CAP_CIP1,
    CAP_TRAILER,
    CAP_CELL_LO,
    CAP_CELL_HI
  } dvfh_cap_kind_t;

  typedef struct packed {
    logic valid;
    dvfh_cap_kind_t kind;
    logic [31:0] word;
  } dvfh_rx_capture_t;

  typedef struct packed {
    logic last;
    logic [31:0] quad;
  } dvfh_tx_word_t;

  typedef struct packed {
    logic enable;
    logic [63:0] bytes;
  } dvfh_cell_insert_t;

endpackage : dvfh_pkg
`default_nettype wire

// >>> test/dv_fifo_header_ports_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dvfh_defines.svh"

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module dv_fifo_header_ports_tb;
  logic pclk, presetn, soft_reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, lo, hi, w;
  logic [32:0] tq;
  logic pready, pslverr, rd_err, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [31:0] rx_quad, rx_last, st;
  logic ack_not_busy, addr_advance;
  dvfh_pkg::dvfh_tx_word_t tx_word;
  dvfh_pkg::dvfh_rx_capture_t rx_capture;
  dvfh_pkg::dvfh_cell_insert_t cell_insert;
  int n_mismatch, checks_done;
  logic [31:0] rxq[$];
  logic [32:0] txq[$];
  logic [31:0] cap_m[6];
  logic [11:0] cap_a[6] = '{`DVFH_OFF_RX_ISO, `DVFH_OFF_RX_CIP0,
    `DVFH_OFF_RX_CIP1, `DVFH_OFF_RX_TRAILER, `DVFH_OFF_RX_CELL_LO,
    `DVFH_OFF_RX_CELL_HI};

  dvfh_regs #(.FIFO_DEPTH(8)) DUT (.pclk(pclk), .presetn(presetn),
    .soft_reset(soft_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_quad(rx_quad), .rx_ready(rx_ready), .rx_capture(rx_capture),
    .ack_not_busy(ack_not_busy), .cell_insert(cell_insert),
    .addr_advance(addr_advance));

  // free-running bus clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // xorshift keeps the stimulus repeatable from one run to the next
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd

  // what each captured register should hold after one capture pulse
  function automatic logic [31:0] cap_exp(int k, logic v, logic [31:0] d,
                                          logic [31:0] old);
    case (k)
      0: return d;
      1: return d & 32'h3fff_ffff;
      2: return ((d & 32'h3fff_ffff) | 32'h8000_0000)
                & (v ? 32'hfffc_ffff : 32'hffff_ffff);
      3: return d & 32'h0003_000f;
      default: return v ? d : old;
    endcase
  endfunction : cap_exp

  task automatic end_of_test();
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++;
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("pslverr", ee, rd_err)
    if (!ee) `CHK("prdata", e, rd_q)
  endtask : rd

  // receive fifo read with the model's pop or repeat of last value
  task automatic rx_read();
    if (rxq.size() > 0) rx_last = rxq.pop_front();
    rd(`DVFH_OFF_RX_DATA, rx_last, 1'b0);
  endtask : rx_read

  task automatic cap(input int k, input logic [31:0] d);
    @(posedge pclk);
    rx_capture <= '{valid: 1'b1, kind: dvfh_pkg::dvfh_cap_kind_t'(k),
                    word: d};
    @(posedge pclk);
    rx_capture.valid <= 1'b0;
  endtask : cap

  task automatic ack_pulse(input logic e);
    @(posedge pclk);
    ack_not_busy <= 1'b1;
    @(posedge pclk);
    ack_not_busy <= 1'b0;
    @(posedge pclk);
    `CHK("addr_advance", e, addr_advance)
  endtask : ack_pulse

  task automatic check_cleared();
    foreach (cap_m[i]) cap_m[i] = 32'h0000_0000;
    rx_last = 32'h0000_0000;
    rxq.delete();
    foreach (cap_a[i]) rd(cap_a[i], 32'h0000_0000, 1'b0);
    rd(`DVFH_OFF_RX_DATA, 32'h0000_0000, 1'b0);
    rd(`DVFH_OFF_AUTO_HDR0, 32'h0001_0010, 1'b0);
  endtask : check_cleared

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    st = 32'h996e;
    n_mismatch = 0;
    checks_done = 0;
    {presetn, soft_reset, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {tx_ready, rx_valid, ack_not_busy} = 3'h0;
    rx_quad = 32'h0000_0000;
    rx_capture = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check_cleared();
    rd(12'h16c, 32'h0000_0000, 1'b1);
    // fill the receive fifo past its depth; it must refuse the surplus
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_quad);
      rx_valid <= (i < 10);
      rx_quad <= rnd();
    end
    `CHK("rx accepted", 8, rxq.size())
    `CHK("rx_ready", 1'b0, rx_ready)
    apb(1'b1, `DVFH_OFF_RX_DATA, 32'h1234_5678);
    repeat (10) rx_read();
    // a write to the isochronous header register changes nothing
    apb(1'b1, `DVFH_OFF_RX_ISO, 32'hffff_ffff);
    rd(`DVFH_OFF_RX_ISO, 32'h0000_0000, 1'b0);
    // captures with video mode off and then on
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `DVFH_OFF_CTRL, {30'h0, v[0], 1'b0});
      for (int k = 0; k < 6; k++) begin
        w = rnd();
        cap(k, w);
        cap_m[k] = cap_exp(k, v[0], w, cap_m[k]);
        rd(cap_a[k], cap_m[k], 1'b0);
      end
    end
    // transmit: continue words wait until the packet is committed
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      txq.push_back({i == 3, w});
      apb(1'b1, i == 3 ? `DVFH_OFF_TX_LAST : `DVFH_OFF_TX_FIRST, w);
      if (i == 2) begin
        repeat (4) @(posedge pclk);
        `CHK("tx_valid", 1'b0, tx_valid)
        rd(`DVFH_OFF_TX_LAST, 32'h0000_0000, 1'b0);
      end
    end
    repeat (6) @(posedge pclk);
    `CHK("tx_word head", txq[0], tx_word)
    tx_ready <= 1'b1;
    for (int n = 0; n < 40 && txq.size() > 0; n++) begin
      @(posedge pclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        tq = txq.pop_front();
        `CHK("tx_word", tq, tx_word)
        `CHK("tx_quad", tq[31:0], tx_word.quad)
      end
    end
    `CHK("tx left", 0, txq.size())
    @(posedge pclk);
    `CHK("tx_valid idle", 1'b0, tx_valid)
    // cell header bytes offered for insertion once enabled
    lo = rnd();
    hi = rnd();
    apb(1'b1, `DVFH_OFF_TX_CELL_LO, lo);
    apb(1'b1, `DVFH_OFF_TX_CELL_HI, hi);
    apb(1'b1, `DVFH_OFF_CTRL, 32'h0000_0001);
    rd(`DVFH_OFF_TX_CELL_LO, lo, 1'b0);
    rd(`DVFH_OFF_TX_CELL_HI, hi, 1'b0);
    `CHK("cell_insert", {1'b1, lo, hi}, cell_insert)
    // auto header: reserved bits read zero, increment bit drives advance
    apb(1'b1, `DVFH_OFF_AUTO_HDR0, 32'hffff_ffff);
    rd(`DVFH_OFF_AUTO_HDR0, 32'h8003_ffff, 1'b0);
    ack_pulse(1'b1);
    apb(1'b1, `DVFH_OFF_AUTO_HDR0, 32'h0000_0000);
    ack_pulse(1'b0);
    // software reset restores every documented reset value
    apb(1'b1, `DVFH_OFF_AUTO_HDR0, 32'h8000_0000);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    check_cleared();
    ack_pulse(1'b0);
    end_of_test();
  end
endmodule : dv_fifo_header_ports_tb

`default_nettype wire
